// ===== common/prhp_pkg.sv
// Constants and carrier types for the parallel register host port
`default_nettype none

package prhp_pkg;
	// Widths
	localparam int          CORE_ADDR_W    = 7;
	localparam int          CORE_DATA_W    = 8;
	localparam int          HOST_DATA_W    = 16;
	localparam int          HOST_ADDR_W    = 6;
	localparam int          REG_COUNT      = 128;
	// Frozen multi-byte window, bytes 10h..17h
	localparam int          FRZ_BASE       = 16;
	localparam int          FRZ_COUNT      = 8;
	localparam int          FRZ_IDX_W      = 3;
	// Core timing
	localparam int          READ_LAT       = 2;
	localparam logic [2:0]  PH_PRE_COMMIT  = 3'h1;
	localparam logic [2:0]  PH_COMMIT      = 3'h3;
	localparam logic [2:0]  PH_RELEASE     = 3'h2;
	// APB map
	localparam logic [11:0] OFS_CTRL       = 12'h000;
	localparam logic [11:0] OFS_STATUS     = 12'h004;
	localparam int          CTRL_EN_BIT    = 0;
	localparam int          CTRL_FRZ_BIT   = 1;
	localparam logic        CTRL_EN_RESET  = 1'h1;
	localparam logic        CTRL_FRZ_RESET = 1'h0;
	localparam int          STAT_PHASE_LSB = 0;
	localparam int          STAT_BUSY_BIT  = 3;
	localparam int          STAT_FRZ_BIT   = 4;
	localparam int          STAT_PEND_LSB  = 8;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_SETUP = 3'b001,
		ST_READ  = 3'b010,
		ST_WRITE = 3'b011,
		ST_DONE  = 3'b100
	} prhp_state_t;

	typedef struct packed {
		logic                   ce_n;
		logic                   oe_n;
		logic                   we_n;
		logic [1:0]             host_byte_lane_n;
		logic                   bank;
		logic [HOST_ADDR_W-1:0] addr;
		logic [HOST_DATA_W-1:0] host_write_data;
		logic                   freeze;
		logic                   narrow_bus_select;
		logic                   bigend;
	} prhp_host_in_t;

	localparam prhp_host_in_t HOST_IDLE = '{ce_n: 1'h1, oe_n: 1'h1, we_n: 1'h1,
		host_byte_lane_n: 2'h3, default: '0};

	typedef struct packed {
		logic [CORE_ADDR_W-1:0] addr;
		logic [CORE_DATA_W-1:0] core_write_data;
		logic                   rd;
		logic                   wr;
		logic                   frz;
	} prhp_core_req_t;

	typedef struct packed {
		logic                   valid;
		logic [CORE_ADDR_W-1:0] addr;
		logic [CORE_DATA_W-1:0] data;
	} prhp_update_t;

	typedef struct packed {
		prhp_host_in_t                            host_s1;
		prhp_host_in_t                            host_s2;
		logic                                     lclk_s1;
		logic                                     lclk_s2;
		logic                                     lclk_s3;
		prhp_host_in_t                            bus;
		prhp_state_t                              state;
		logic                                     lane;
		logic [1:0]                               lanes;
		logic                                     is_write;
		logic [1:0]                               cnt;
		prhp_core_req_t                           core;
		logic [CORE_DATA_W-1:0]                   rd_data;
		logic [2:0]                               phase;
		logic [REG_COUNT-1:0][CORE_DATA_W-1:0]    mem;
		logic [FRZ_COUNT-1:0][CORE_DATA_W-1:0]    shadow;
		logic [FRZ_COUNT-1:0]                     pend;
		logic [HOST_DATA_W-1:0]                   host_rdata;
		logic                                     host_wait;
		logic                                     ctrl_en;
		logic                                     ctrl_frz;
		logic                                     pready;
		logic [31:0]                              prdata;
		logic                                     pslverr;
	} prhp_regs_t;

	localparam prhp_regs_t REGS_RESET = '{host_s1: HOST_IDLE, host_s2: HOST_IDLE,
		bus: HOST_IDLE, state: ST_IDLE, ctrl_en: CTRL_EN_RESET,
		ctrl_frz: CTRL_FRZ_RESET, default: '0};
endpackage : prhp_pkg

`default_nettype wire

// ===== hdl/prhp_port.sv
// Parallel host port with core byte register block, timing phase and freeze
//
// Overview of operation
// (R01) Separate 16-bit host write and read buses
// (R02) Host address picks 16-bit register pair
// (R03) Narrow mode: bank bit picks byte
// (R04) Both byte lanes low: two byte accesses
// (R05) Chip select high: no register access
// (R06) Output enable times read data toward host
// (R07) Write enable times host register write
// (R08) Wait output stretches cycle until done
// (R09) Freeze pin holds multi-byte registers
// (R10) Width select: 0 wide, 1 narrow
// (R11) Byte order select maps bytes to lanes
// (R12) Core port: 7-bit address, 8-bit data
// (R13) Client raises separate read, write flags
// (R14) Core freeze stops multi-byte visible updates
// (R15) Frozen updates stored, copied after unfreeze
// (R16) Host keeps freeze over whole multi-read
// (R17) Core outputs 3-bit timing phase
// (R18) Write captured at one fixed phase
// (R19) Read data within two cycles, held
// (R20) Commit at 001 to 011, hold to 010
// (R21) Gray phase each cycle, one write per eight
// (R22) Freeze raised one cycle before reads
// (R23) Host strobes synchronised into core clock
`default_nettype none

module prhp_port (
	// Clock and reset
	input  wire logic                     mclk,
	input  wire logic                     rst,
	// APB slave
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	// Host parallel bus
	input  wire logic                     link_clk,
	input  wire prhp_pkg::prhp_host_in_t  host_in,
	output logic [prhp_pkg::HOST_DATA_W-1:0] host_read_data,
	output logic                          host_wait,
	// Core refresh source
	input  wire prhp_pkg::prhp_update_t   core_update,
	// Core basic interface view
	output prhp_pkg::prhp_core_req_t      core_req,
	output logic [prhp_pkg::CORE_DATA_W-1:0] core_read_data,
	output logic [2:0]                    timing_phase
);
	import prhp_pkg::*;

	prhp_regs_t r_reg;
	prhp_regs_t r_next;

	function automatic logic [2:0] gray_inc(input logic [2:0] g);
		logic [2:0] b;
		b[2] = g[2];
		b[1] = g[2] ^ g[1];
		b[0] = b[1] ^ g[0];
		b = b + 3'h1;
		return b ^ (b >> 1);
	endfunction : gray_inc

	// Byte address of a lane; big-endian puts the low lane on the odd byte
	function automatic logic [CORE_ADDR_W-1:0] byte_addr(input prhp_host_in_t b,
			input logic lane);
		if (b.narrow_bus_select) begin
			return {b.addr, b.bank}; // (R03)
		end
		return {b.addr, lane ^ b.bigend}; // (R02) (R11)
	endfunction : byte_addr

	function automatic logic [CORE_DATA_W-1:0] lane_byte(input logic [HOST_DATA_W-1:0] d,
			input logic lane);
		return lane ? d[15:8] : d[7:0];
	endfunction : lane_byte

	always_comb begin
		logic                   active;
		logic                   sel;
		logic [CORE_ADDR_W-1:0] off;
		logic [31:0]            rdv;
		active = 1'b0;
		sel    = 1'b0;
		off    = '0;
		rdv    = '0;
		r_next = r_reg;

		// Host pins are asynchronous; take them at the seen falling link edge,
		// mid-period, so a host launching on the rising edge has settled
		r_next.host_s1 = host_in; // (R23)
		r_next.host_s2 = r_reg.host_s1;
		r_next.lclk_s1 = link_clk;
		r_next.lclk_s2 = r_reg.lclk_s1;
		r_next.lclk_s3 = r_reg.lclk_s2;
		if (!r_reg.lclk_s2 && r_reg.lclk_s3) begin
			r_next.bus = r_reg.host_s2; // (R23)
		end

		r_next.phase    = gray_inc(r_reg.phase); // (R17) (R21)
		r_next.core.frz = r_reg.bus.freeze | r_reg.ctrl_frz; // (R09)

		active = !r_reg.bus.ce_n && (!r_reg.bus.oe_n || !r_reg.bus.we_n) // (R05)
			&& r_reg.ctrl_en;

		case (r_reg.state)
			ST_IDLE: begin
				r_next.host_wait = 1'b0;
				if (active) begin
					r_next.host_wait = 1'b1; // (R08)
					r_next.is_write  = !r_reg.bus.we_n; // (R07)
					r_next.lanes     = r_reg.bus.narrow_bus_select ? 2'b01 // (R10)
						: ~r_reg.bus.host_byte_lane_n; // (R04)
					r_next.state     = ST_SETUP;
				end
			end
			// Setup also gives freeze its lead cycle ahead of the first read
			ST_SETUP: begin
				if (r_reg.lanes == 2'b00) begin
					r_next.host_wait = 1'b0;
					r_next.state     = ST_DONE;
				end else begin
					sel                       = !r_reg.lanes[0]; // (R04)
					r_next.lane               = sel;
					r_next.core.addr          = byte_addr(r_reg.bus, sel); // (R12)
					r_next.core.core_write_data =
						lane_byte(r_reg.bus.host_write_data, sel); // (R01)
					r_next.cnt                = 2'h0;
					if (r_reg.is_write) begin
						r_next.core.wr = 1'b1;
						r_next.state   = ST_WRITE;
					end else begin
						r_next.core.rd = 1'b1; // (R22)
						r_next.state   = ST_READ;
					end
				end
			end
			ST_READ: begin
				r_next.cnt = r_reg.cnt + 2'h1;
				if (r_reg.cnt == 2'(READ_LAT - 1)) begin
					if (r_reg.lane) begin
						r_next.host_rdata[15:8] = r_reg.rd_data; // (R06)
					end else begin
						r_next.host_rdata[7:0] = r_reg.rd_data; // (R06)
					end
					r_next.core.rd           = 1'b0;
					r_next.lanes[r_reg.lane] = 1'b0;
					r_next.state             = ST_SETUP;
				end
			end
			// Write flag stays until commit passed and phase reaches 010
			ST_WRITE: begin
				if (r_reg.phase == PH_PRE_COMMIT) begin
					r_next.cnt[0] = 1'b1;
				end
				if (r_reg.cnt[0] && r_reg.phase == PH_RELEASE) begin
					r_next.core.wr           = 1'b0; // (R20)
					r_next.lanes[r_reg.lane] = 1'b0;
					r_next.state             = ST_SETUP;
				end
			end
			ST_DONE: begin
				r_next.host_wait = 1'b0;
				if (!active) begin
					r_next.state = ST_IDLE;
				end
			end
			default: begin
				r_next.state = ST_IDLE;
			end
		endcase

		// Core register block
		if (r_reg.core.rd) begin
			r_next.rd_data = r_reg.mem[r_reg.core.addr]; // (R19)
		end
		if (!r_reg.core.frz) begin
			for (int i = 0; i < FRZ_COUNT; i++) begin
				if (r_reg.pend[i]) begin
					r_next.mem[FRZ_BASE + i] = r_reg.shadow[i]; // (R15)
				end
			end
			r_next.pend = '0;
		end
		if (core_update.valid) begin
			off = core_update.addr - 7'(FRZ_BASE);
			if (r_reg.core.frz && core_update.addr >= 7'(FRZ_BASE)
					&& core_update.addr < 7'(FRZ_BASE + FRZ_COUNT)) begin
				r_next.shadow[off[FRZ_IDX_W-1:0]] = core_update.data; // (R14)
				r_next.pend[off[FRZ_IDX_W-1:0]]   = 1'b1; // (R15)
			end else begin
				r_next.mem[core_update.addr] = core_update.data;
			end
		end
		// Host write wins over a refresh of the same byte, except a frozen refresh, which is copied over it on unfreeze
		if (r_reg.core.wr && r_reg.phase == PH_PRE_COMMIT) begin
			r_next.mem[r_reg.core.addr] = r_reg.core.core_write_data; // (R18) (R20)
		end

		// APB: one wait state, answer in second access cycle
		r_next.pready  = 1'b0;
		r_next.pslverr = 1'b0;
		if (psel && penable && !r_reg.pready) begin
			r_next.pready = 1'b1;
			case (paddr)
				OFS_CTRL: begin
					rdv[CTRL_EN_BIT]  = r_reg.ctrl_en;
					rdv[CTRL_FRZ_BIT] = r_reg.ctrl_frz;
				end
				OFS_STATUS: begin
					rdv[STAT_PHASE_LSB +: 3]        = r_reg.phase;
					rdv[STAT_BUSY_BIT]              = r_reg.host_wait;
					rdv[STAT_FRZ_BIT]               = r_reg.core.frz;
					rdv[STAT_PEND_LSB +: FRZ_COUNT] = r_reg.pend;
				end
				default: begin
					r_next.pslverr = 1'b1;
				end
			endcase
			r_next.prdata = rdv;
		end
		if (psel && penable && r_reg.pready && pwrite && paddr == OFS_CTRL) begin
			r_next.ctrl_en  = pwdata[CTRL_EN_BIT];
			r_next.ctrl_frz = pwdata[CTRL_FRZ_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			r_reg <= REGS_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	assign prdata         = r_reg.prdata;
	assign pready         = r_reg.pready;
	assign pslverr        = r_reg.pslverr;
	assign host_read_data = r_reg.host_rdata;
	assign host_wait      = r_reg.host_wait;
	assign core_req       = r_reg.core;
	assign core_read_data = r_reg.rd_data;
	assign timing_phase   = r_reg.phase;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	rd_latency_a: assert property ($rose(r_reg.core.rd) |=> // (R19)
		r_reg.rd_data == $past(r_reg.mem[r_reg.core.addr]))
		else $error("read data not presented in time");
	write_commit_a: assert property ((r_reg.core.wr && r_reg.phase == PH_PRE_COMMIT) |=> // (R20)
		(r_reg.phase == PH_COMMIT
		&& r_reg.mem[$past(r_reg.core.addr)] == $past(r_reg.core.core_write_data)))
		else $error("write not committed at phase 001 to 011");
	write_hold_a: assert property ($fell(r_reg.core.wr) |-> // (R20)
		$past(r_reg.phase) == PH_RELEASE)
		else $error("write flag dropped before phase 010");
	phase_gray_a: assert property (!$past(rst) |-> // (R21)
		$countones(r_reg.phase ^ $past(r_reg.phase)) == 1)
		else $error("timing phase not a one-bit step");
	freeze_hold_a: assert property ((r_reg.core.frz && $past(r_reg.core.frz) // (R14)
		&& !$past(r_reg.core.wr)) |-> $stable(r_reg.mem[FRZ_BASE +: FRZ_COUNT]))
		else $error("frozen bytes changed");
	pend_copy_a: assert property (!r_reg.core.frz |=> r_reg.pend == '0) // (R15)
		else $error("pending refresh not copied after unfreeze");
	chip_select_a: assert property ((r_reg.state == ST_IDLE && r_reg.bus.ce_n) // (R05)
		|=> r_reg.state == ST_IDLE && !r_reg.core.rd && !r_reg.core.wr)
		else $error("access started without chip select");
	wait_busy_a: assert property ((r_reg.state inside {ST_READ, ST_WRITE}) // (R08)
		|-> r_reg.host_wait)
		else $error("wait low during core access");
	two_lanes_a: assert property (($past(r_reg.lanes) == 2'b11 // (R04)
		&& r_reg.lanes != $past(r_reg.lanes) && r_reg.state != ST_IDLE)
		|-> r_reg.lanes == 2'b10)
		else $error("two-byte access lost its second byte");
	narrow_addr_a: assert property ((r_reg.state == ST_SETUP && r_reg.lanes != 2'b00 // (R03)
		&& r_reg.bus.narrow_bus_select) |=> r_reg.core.addr[0] == $past(r_reg.bus.bank))
		else $error("narrow access ignored bank bit");

	wait_done_a: assert property ((r_reg.state == ST_DONE) // (R08)
		|-> !r_reg.host_wait)
		else $error("wait still high after last byte");
	setup_wait_a: assert property ((r_reg.state == ST_SETUP && r_reg.lanes != 2'b00) // (R08)
		|-> r_reg.host_wait)
		else $error("wait low while bytes remain");
	idle_quiet_a: assert property ((r_reg.state == ST_IDLE) // (R05)
		|-> !r_reg.core.rd && !r_reg.core.wr)
		else $error("core flag raised while port idle");
	disabled_idle_a: assert property ((r_reg.state == ST_IDLE && !r_reg.ctrl_en) // (R05)
		|=> r_reg.state == ST_IDLE)
		else $error("access started while port disabled");
	rw_split_a: assert property (r_reg.core.rd // (R13)
		|-> !r_reg.core.wr)
		else $error("read and write flags raised together");
	write_kind_a: assert property (r_reg.core.wr // (R07)
		|-> r_reg.is_write)
		else $error("write flag raised for a read access");
	wdata_lane_a: assert property ((r_reg.state == ST_WRITE) // (R01)
		|-> r_reg.core.core_write_data == (r_reg.lane ? r_reg.bus.host_write_data[15:8]
		: r_reg.bus.host_write_data[7:0]))
		else $error("write byte not taken from its lane");
	wide_addr_a: assert property ((r_reg.state == ST_SETUP && r_reg.lanes != 2'b00 // (R02)
		&& !r_reg.bus.narrow_bus_select) |=> r_reg.core.addr[6:1] == $past(r_reg.bus.addr))
		else $error("wide access left its 16-bit location");
	byte_order_a: assert property ((r_reg.state == ST_SETUP && r_reg.lanes == 2'b10 // (R11)
		&& !r_reg.bus.narrow_bus_select) |=> r_reg.core.addr[0] == !$past(r_reg.bus.bigend))
		else $error("high lane mapped to wrong byte");
	narrow_lane_a: assert property ((r_reg.state == ST_SETUP // (R10)
		&& r_reg.bus.narrow_bus_select) |-> !r_reg.lanes[1])
		else $error("narrow access used the high lane");
	read_flag_a: assert property ((r_reg.state == ST_READ) // (R19)
		|-> r_reg.core.rd)
		else $error("read flag low during core read");
	read_drop_a: assert property ((r_reg.state == ST_READ // (R19)
		&& r_reg.cnt == 2'(READ_LAT - 1)) |=> !r_reg.core.rd)
		else $error("read flag not released after data");
	write_flag_a: assert property ((r_reg.state == ST_WRITE) // (R20)
		|-> r_reg.core.wr)
		else $error("write flag low during core write");
	commit_gap_a: assert property ((r_reg.core.wr && r_reg.phase == PH_PRE_COMMIT) // (R21)
		|=> !(r_reg.core.wr && r_reg.phase == PH_PRE_COMMIT) [*7])
		else $error("two writes committed within eight cycles");
	pend_set_a: assert property ((core_update.valid && r_reg.core.frz // (R15)
		&& core_update.addr == 7'(FRZ_BASE)) |=> r_reg.pend[0])
		else $error("frozen refresh not kept aside");
	rdata_hold_a: assert property ((r_reg.state != ST_READ) // (R06)
		|=> $stable(r_reg.host_rdata))
		else $error("host read data changed outside a read");
	phase_start_a: assert property ($past(rst) // (R17)
		|-> r_reg.phase == 3'h0)
		else $error("timing phase not at 000 after reset");

	read_cov_c: cover property (r_reg.state == ST_READ ##1 r_reg.state == ST_READ
		##1 r_reg.state == ST_SETUP);
	write_cov_c: cover property (r_reg.core.wr && r_reg.phase == PH_PRE_COMMIT);
	dual_cov_c: cover property (r_reg.state == ST_SETUP && r_reg.lanes == 2'b11);
	unfreeze_cov_c: cover property ($fell(r_reg.core.frz) && r_reg.pend != '0);
	narrow_cov_c: cover property (r_reg.state == ST_SETUP && r_reg.bus.narrow_bus_select
		&& r_reg.lanes == 2'b01);
endmodule : prhp_port

`default_nettype wire

// ===== bench/prhp_host_model.sv
// Host memory bus master model facing the parallel port
`default_nettype none

module prhp_host_model (
	// Clocks
	input  wire logic                    mclk,
	output var  logic                    link_clk,
	// Host bus
	output var  prhp_pkg::prhp_host_in_t host_in,
	input  wire logic [15:0]             host_read_data,
	input  wire logic                    host_wait
);
	import prhp_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	logic frz;

	// Host clock runs free, as a real memory bus clock does
	initial begin
		link_clk = 1'b0;
		frz = 1'b0;
		host_in = HOST_IDLE;
		forever #80 link_clk = ~link_clk;
	end

	// One strobed access; wait is watched on the fast clock so no pulse is missed
	task automatic acc(input logic w, n, b, be, c, input logic [1:0] ln,
		input logic [5:0] a, input logic [15:0] d, output logic [15:0] q, output logic s);
		int i;
		s = 1'b0;
		@(posedge link_clk);
		host_in <= '{ce_n: c, oe_n: w, we_n: !w, host_byte_lane_n: ln, bank: b, addr: a,
			host_write_data: d, freeze: frz, narrow_bus_select: n, bigend: be};
		for (i = 0; i < 80 && !s; i++) @(posedge mclk) s = host_wait;
		for (i = 0; i < 200 && s && host_wait; i++) @(posedge mclk);
		@(posedge link_clk);
		q = host_read_data;
		// Released lines show no stale value
		host_in <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, host_byte_lane_n: 2'h3, bank: ~b,
			addr: ~a, host_write_data: ~d, freeze: frz, narrow_bus_select: n, bigend: be};
		repeat (2) @(posedge link_clk);
	endtask : acc
endmodule : prhp_host_model

`default_nettype wire

// ===== bench/prhp_port_tb_top.sv
// Self-checking bench for the parallel host port
`default_nettype none

module prhp_port_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import prhp_pkg::*;

	localparam logic [2:0] G [8] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h7, 3'h5, 3'h4};

	logic           mclk, rst, psel, penable, pwrite, pready, pslverr, link_clk, host_wait;
	logic [11:0]    paddr;
	logic [31:0]    pwdata, prdata;
	logic [15:0]    host_read_data;
	logic [7:0]     core_read_data;
	logic [2:0]     timing_phase;
	prhp_host_in_t  host_in;
	prhp_update_t   core_update;
	prhp_core_req_t core_req;
	int             failures, num_checks, cyc;

	prhp_port uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link_clk(link_clk), .host_in(host_in), .host_read_data(host_read_data),
		.host_wait(host_wait), .core_update(core_update), .core_req(core_req),
		.core_read_data(core_read_data), .timing_phase(timing_phase));

	prhp_host_model uhm (.mclk(mclk), .link_clk(link_clk), .host_in(host_in),
		.host_read_data(host_read_data), .host_wait(host_wait));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic results;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : results

	// Hang guard, far above the expected few thousand cycles
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			failures++;
			results();
		end
	end

	task automatic chk(input logic [39:0] g, x);
		num_checks++;
		if (g !== x) begin
			failures++;
			$display("Error t=%0t got %h exp %h", $time, g, x);
		end
	endtask : chk

	// Request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic upd(input logic [7:0] d);
		@(posedge mclk);
		core_update <= '{valid: 1'b1, addr: 7'h10, data: d};
		@(posedge mclk);
		core_update.valid <= 1'b0;
	endtask : upd

	initial begin
		logic [31:0] q;
		logic        e, s;
		logic [15:0] h;
		logic [2:0]  ph [9];
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		core_update = '0;
		{failures, num_checks, cyc} = '0;
		repeat (2) @(posedge mclk);
		chk({core_req, host_wait, timing_phase}, '0);
		rst <= 1'b0;
		// Sampled mid-cycle, away from the launching edge
		for (int j = 0; j < 9; j++) @(negedge mclk) ph[j] = timing_phase;
		for (int j = 0; j < 9; j++) chk(ph[j], G[j % 8]);
		$display("phase test done");
		apb(1'b0, OFS_CTRL, 32'h0, q, e);
		chk({q, e}, {32'h1, 1'b0});
		apb(1'b1, OFS_CTRL, 32'h3, q, e);
		apb(1'b0, OFS_CTRL, 32'h0, q, e);
		chk({q, e}, {32'h3, 1'b0});
		apb(1'b1, OFS_CTRL, 32'h1, q, e);
		apb(1'b0, 12'h008, 32'h0, q, e);
		chk({q, e}, {32'h0, 1'b1});
		$display("register test done");
		uhm.acc(1, 0, 0, 0, 0, 2'h0, 6'h05, 16'hbeef, h, s);
		uhm.acc(0, 0, 1, 0, 0, 2'h0, 6'h05, 16'h0, h, s);
		chk(h, 16'hbeef);
		uhm.acc(0, 0, 0, 1, 0, 2'h0, 6'h05, 16'h0, h, s);
		chk(h, 16'hefbe);
		chk({core_req.addr, core_read_data}, {7'h0a, 8'hef});
		uhm.acc(1, 1, 1, 0, 0, 2'h3, 6'h06, 16'h005a, h, s);
		uhm.acc(0, 1, 1, 0, 0, 2'h3, 6'h06, 16'h0, h, s);
		chk(h[7:0], 8'h5a);
		uhm.acc(0, 0, 1, 0, 0, 2'h0, 6'h06, 16'h0, h, s);
		chk(h, 16'h5a00);
		$display("width test done");
		uhm.acc(1, 0, 0, 0, 0, 2'h2, 6'h07, 16'h1234, h, s);
		uhm.acc(1, 0, 0, 0, 1, 2'h0, 6'h07, 16'hffff, h, s);
		chk(s, 1'b0);
		apb(1'b1, OFS_CTRL, 32'h0, q, e);
		uhm.acc(1, 0, 0, 0, 0, 2'h0, 6'h07, 16'hffff, h, s);
		chk(s, 1'b0);
		apb(1'b1, OFS_CTRL, 32'h1, q, e);
		uhm.acc(0, 0, 0, 0, 0, 2'h0, 6'h07, 16'h0, h, s);
		chk(h, 16'h0034);
		$display("lane and select test done");
		upd(8'h11);
		uhm.acc(0, 0, 0, 0, 0, 2'h0, 6'h08, 16'h0, h, s);
		chk(h, 16'h0011);
		uhm.frz = 1'b1;
		uhm.acc(0, 0, 0, 0, 0, 2'h0, 6'h08, 16'h0, h, s);
		chk(core_req.frz, 1'b1);
		upd(8'h22);
		uhm.acc(0, 0, 0, 0, 0, 2'h0, 6'h08, 16'h0, h, s);
		chk(h, 16'h0011);
		apb(1'b0, OFS_STATUS, 32'h0, q, e);
		chk(q & 32'h0110, 32'h0110);
		uhm.frz = 1'b0;
		uhm.acc(0, 0, 0, 0, 0, 2'h0, 6'h08, 16'h0, h, s);
		chk(h, 16'h0022);
		$display("freeze test done");
		results();
	end
endmodule : prhp_port_tb_top

`default_nettype wire
